// File: core_ctrl.sv
// status word, table base, memory bases and fetch/execute pipeline control
//==========================================================
`timescale 1ns/1ps
`include "core_defs.svh"
module core_ctrl
    import core_pkg::*;
(
    input  wire logic        CLK,          // core clock, 40 MHz
    input  wire logic        RST_N,        // synchronous reset, active low
    output logic [31:0]      BUS_ADDR,     // shared address bus
    output logic             BUS_REQ,      // bus cycle request
    output logic             BUS_WRITE,    // cycle is a write
    output logic [31:0]      BUS_WDATA,    // write data bus
    input  wire logic [31:0] BUS_RDATA,    // read data bus
    input  wire logic        BUS_ACK,      // read or write completes
    input  wire logic        OPND_REQ,     // execute wants an operand cycle
    input  wire logic        OPND_WRITE,   // operand cycle is a write
    input  wire logic [31:0] OPND_ADDR,    // operand address
    input  wire logic [31:0] OPND_WDATA,   // operand store data
    output logic             OPND_DONE,    // operand cycle finished
    output logic [31:0]      OPND_RDATA,   // operand read data
    output logic [31:0]      INST_WORD,    // instruction word to execute
    output logic             INST_VALID,   // instruction word offered
    input  wire logic        INST_TAKE,    // execute issues offered word
    input  wire op_class_t   INST_CLASS,   // class of issued word
    output logic             EXEC_BUSY,    // execute stage occupied
    input  wire logic        FLOW_VALID,   // change of flow resolved
    input  wire logic        FLOW_MISPRED, // outcome differs from guess
    input  wire logic [31:0] FLOW_TARGET,  // target from execute
    input  wire logic        BR_COND,      // conditional branch decoded
    input  wire logic        BR_BACKWARD,  // branch displacement negative
    output logic             BR_PREDICT,   // predicted taken
    input  wire logic        CR_WE,        // control register write
    input  wire ctl_reg_t    CR_SEL,       // control register select
    input  wire logic [31:0] CR_WDATA,     // control register write data
    output logic [31:0]      CR_RDATA,     // control register read data
    input  wire logic        INSN_DONE,    // an instruction completed
    output logic             TRACE_REQ,    // trace exception due
    input  wire logic [2:0]  IRQ_LEVEL,    // pending interrupt level
    input  wire logic        IRQ_EDGE7,    // edge-sensitive level seven
    output logic             IRQ_TAKE,     // interrupt not masked
    input  wire logic        IRQ_ENTRY,    // interrupt exception begins
    input  wire logic [9:0]  VEC_DISP,     // vector displacement
    output logic [31:0]      VEC_ADDR,     // vector fetch address
    input  wire logic        STK_SWAP_WE,  // write alternate stack
    input  wire logic [31:0] STK_WDATA,    // stack write data
    output logic [31:0]      ACTIVE_SP,    // active stack pointer
    output logic [31:0]      ALT_SP,       // alternate stack pointer
    output logic             SUPERVISOR,   // privilege level
    output logic             SRAM_HIT,     // address maps to sram
    output logic             FLASH_HIT,    // address maps to flash
    output logic             WRITE_BLOCK   // write to protected memory
);
    //==========================================================
    // state
    typedef enum logic [2:0] {ST_RST_SP, ST_RST_PC, ST_RUN, ST_FETCH, ST_OPND} fst_t;
    fst_t        st_ff;
    logic [31:0] pfa_ff;        // fetch_addr_stage prefetch address
    logic [31:0] iar_ff;        // instruction_address_reg
    logic [31:0] tbl_ff;        // exception_table_base
    logic [15:0] psw_ff;        // processor_status_word
    logic [31:0] sram_base_ff;  // sram_base_reg
    logic [31:0] flash_base_ff; // flash_base_reg
    logic [31:0] act_sp_ff;
    logic [31:0] alt_sp_ff;
    logic [31:0] word_ff;
    logic        word_vld_ff;
    logic        sup_mode;
    logic        bypass;
    logic        fetch_ack;
    logic        cyc_busy;
    ibuf_if      ib ();

    inst_buffer u_ibuf (
        .clk   (CLK),
        .rst_n (RST_N),
        .ib    (ib.buf_side)
    );

    cycle_timer u_timer (
        .clk   (CLK),
        .rst_n (RST_N),
        .start (INST_TAKE && INST_VALID),
        .op    (INST_CLASS),
        .busy  (cyc_busy),
        .last  ()
    );

    function automatic logic base_hit(input logic [31:0] base, input logic [31:0] a);
        return base[`BASE_EN_BIT] && ((a & `BASE_ADDR_MASK) == (base & `BASE_ADDR_MASK));
    endfunction : base_hit

    assign sup_mode = psw_ff[`PSW_SUPER_BIT];

    //==========================================================
    // bus arbitration: operands first, prefetch only when free
    always_comb begin
        BUS_REQ   = 1'b0;
        BUS_WRITE = 1'b0;
        BUS_ADDR  = pfa_ff;
        BUS_WDATA = OPND_WDATA;
        case (st_ff)
            ST_RST_SP: begin
                BUS_REQ  = 1'b1;
                BUS_ADDR = `RST_SP_ADDR;
            end
            ST_RST_PC: begin
                BUS_REQ  = 1'b1;
                BUS_ADDR = `RST_PC_ADDR;
            end
            ST_OPND: begin
                BUS_REQ   = 1'b1;
                BUS_WRITE = OPND_WRITE;
                BUS_ADDR  = OPND_ADDR;
            end
            ST_FETCH: begin
                BUS_REQ = 1'b1;                  // held until data or a flow change
            end
            default: begin
                BUS_REQ = 1'b0;
            end
        endcase
    end

    assign fetch_ack  = (st_ff == ST_FETCH) && BUS_ACK && !FLOW_VALID;
    assign OPND_DONE  = (st_ff == ST_OPND) && BUS_ACK;
    // no bypass while older words sit in the buffer, keeping order
    assign bypass     = fetch_ack && ib.empty && !word_vld_ff && INST_TAKE && !cyc_busy;

    //==========================================================
    // fetch sequencer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_ff <= ST_RST_SP;
        end else begin
            case (st_ff)
                ST_RST_SP: if (BUS_ACK) st_ff <= ST_RST_PC;
                ST_RST_PC: if (BUS_ACK) st_ff <= ST_RUN;
                ST_RUN: begin
                    if (OPND_REQ) st_ff <= ST_OPND;
                    else if (!ib.full && !FLOW_VALID) st_ff <= ST_FETCH;
                end
                ST_FETCH: if (BUS_ACK || FLOW_VALID) st_ff <= ST_RUN;
                ST_OPND:  if (BUS_ACK) st_ff <= ST_RUN;
                default:  st_ff <= ST_RUN;
            endcase
        end
    end

    // prefetch address: step by four, redirect on mispredicted flow
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pfa_ff <= 32'h0;
        end else if (st_ff == ST_RST_PC && BUS_ACK) begin
            pfa_ff <= BUS_RDATA;
        end else if (FLOW_VALID && FLOW_MISPRED) begin
            pfa_ff <= FLOW_TARGET;
        end else if (fetch_ack) begin
            pfa_ff <= pfa_ff + `PREFETCH_STEP;
        end
    end

    assign ib.flush     = FLOW_VALID && FLOW_MISPRED;
    assign ib.push      = fetch_ack && !bypass;
    assign ib.push_data = BUS_RDATA;
    // moving the head into the holding flop is the pop, so no word issues twice
    assign ib.pop       = !word_vld_ff && !cyc_busy;

    // head word held in a flop; issue data comes from it, or from BUS_RDATA on a bypass
    always_ff @(posedge CLK) begin
        if (!RST_N || ib.flush) begin
            word_ff     <= 32'h0;
            word_vld_ff <= 1'b0;
        end else if (!word_vld_ff && !ib.empty && !cyc_busy) begin
            word_ff     <= ib.pop_data;
            word_vld_ff <= 1'b1;
        end else if (INST_TAKE && word_vld_ff && !cyc_busy) begin
            word_vld_ff <= 1'b0;
        end
    end

    // issue waits for a word, either buffered or bypassed
    assign INST_VALID = !cyc_busy && (word_vld_ff || (fetch_ack && ib.empty));
    assign INST_WORD  = word_vld_ff ? word_ff : BUS_RDATA;
    assign EXEC_BUSY  = cyc_busy;
    assign BR_PREDICT = BR_COND && BR_BACKWARD;
    assign OPND_RDATA = BUS_RDATA;

    // executing address tracks issue, and flow targets from execute
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            iar_ff <= 32'h0;
        end else if (st_ff == ST_RST_PC && BUS_ACK) begin
            iar_ff <= BUS_RDATA;
        end else if (FLOW_VALID) begin
            iar_ff <= FLOW_TARGET;
        end else if (INST_TAKE && INST_VALID) begin
            iar_ff <= iar_ff + `PREFETCH_STEP;
        end
    end

    //==========================================================
    // status word: hardware entry beats a software write
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            psw_ff <= `PSW_RESET;
        end else if (IRQ_ENTRY) begin
            psw_ff[`PSW_MASTER_BIT] <= 1'b0;
            psw_ff[`PSW_SUPER_BIT]  <= 1'b1;
            psw_ff[`PSW_TRACE_BIT]  <= 1'b0;
        end else if (CR_WE && CR_SEL == CR_PSW) begin
            // reserved bits forced low, so careless writes stay harmless
            if (sup_mode) psw_ff <= CR_WDATA[15:0] & `PSW_WRITE_MASK;
            else psw_ff[7:0] <= CR_WDATA[7:0];
        end
    end

    // table base and memory bases are supervisor-only
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tbl_ff        <= 32'h0;
            sram_base_ff  <= 32'h0;
            flash_base_ff <= 32'h0;
        end else if (CR_WE && sup_mode) begin
            if (CR_SEL == CR_TBL)   tbl_ff        <= CR_WDATA & `TBL_KEEP_MASK;
            if (CR_SEL == CR_SRAM)  sram_base_ff  <= CR_WDATA;
            if (CR_SEL == CR_FLASH) flash_base_ff <= CR_WDATA;
        end
    end

    // read mux; user mode sees only the flag byte
    always_comb begin
        case (CR_SEL)
            CR_PSW:   CR_RDATA = {16'h0, sup_mode ? psw_ff : (psw_ff & `PSW_USER_MASK)};
            CR_TBL:   CR_RDATA = sup_mode ? tbl_ff : 32'h0;
            CR_SRAM:  CR_RDATA = sup_mode ? sram_base_ff : 32'h0;
            CR_FLASH: CR_RDATA = sup_mode ? flash_base_ff : 32'h0;
            default:  CR_RDATA = 32'h0;
        endcase
    end

    assign VEC_ADDR   = tbl_ff + {22'h0, VEC_DISP};
    assign TRACE_REQ  = psw_ff[`PSW_TRACE_BIT] && INSN_DONE;
    assign IRQ_TAKE   = IRQ_EDGE7 || (IRQ_LEVEL > psw_ff[`PSW_MASK_LSB +: 3]);
    assign SUPERVISOR = sup_mode;
    assign SRAM_HIT   = base_hit(sram_base_ff, BUS_ADDR);
    assign FLASH_HIT  = base_hit(flash_base_ff, BUS_ADDR);
    assign WRITE_BLOCK = BUS_WRITE && ((SRAM_HIT && sram_base_ff[`BASE_WP_BIT]) ||
                                       (FLASH_HIT && flash_base_ff[`BASE_WP_BIT]));

    //==========================================================
    // stack pointers: physical pair, meaning follows privilege
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            act_sp_ff <= 32'h0;
            alt_sp_ff <= 32'h0;
        end else if (st_ff == ST_RST_SP && BUS_ACK) begin
            act_sp_ff <= BUS_RDATA;
        end else if (IRQ_ENTRY ? !sup_mode
                               : (CR_WE && CR_SEL == CR_PSW && sup_mode && !CR_WDATA[`PSW_SUPER_BIT])) begin
            // swap only when the privilege really flips; entry beats the write
            act_sp_ff <= alt_sp_ff;
            alt_sp_ff <= act_sp_ff;
        end else if (STK_SWAP_WE) begin
            alt_sp_ff <= STK_WDATA;
        end
    end

    assign ACTIVE_SP = act_sp_ff;
    assign ALT_SP    = alt_sp_ff;

    //==========================================================
    sequence s_rst_pc_read;
        st_ff == ST_RST_PC && BUS_ACK;
    endsequence
    a_reset_pc_load: assert property (@(posedge CLK) disable iff (!RST_N)
        s_rst_pc_read |=> pfa_ff == $past(BUS_RDATA)) else $error("reset pc not loaded");
    a_iar_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        s_rst_pc_read |=> iar_ff == $past(BUS_RDATA)) else $error("instruction address not loaded");
    a_sp_swap: assert property (@(posedge CLK) disable iff (!RST_N)
        st_ff != ST_RST_SP && !IRQ_ENTRY && CR_WE && CR_SEL == CR_PSW && sup_mode && !CR_WDATA[13]
        |=> ACTIVE_SP == $past(alt_sp_ff)) else $error("stack pair not swapped");
    a_rst_pc_addr: assert property (@(posedge CLK) disable iff (!RST_N)
        st_ff == ST_RST_PC |-> BUS_ADDR == 32'h0000_0004) else $error("reset pc address wrong");
    a_tbl_align: assert property (@(posedge CLK) disable iff (!RST_N)
        tbl_ff[19:0] == 20'h0) else $error("table base low bits set");
    a_seq_plus_four: assert property (@(posedge CLK) disable iff (!RST_N)
        fetch_ack && !FLOW_VALID |=> pfa_ff == $past(pfa_ff) + 32'h4) else $error("prefetch step wrong");
    a_opnd_first: assert property (@(posedge CLK) disable iff (!RST_N)
        st_ff == ST_RUN && OPND_REQ |=> st_ff == ST_OPND) else $error("prefetch beat operand");
    a_fetch_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        st_ff == ST_FETCH && !BUS_ACK && !FLOW_VALID |=> st_ff == ST_FETCH) else $error("fetch left early");
    a_mask_blocks: assert property (@(posedge CLK) disable iff (!RST_N)
        !IRQ_EDGE7 && IRQ_LEVEL <= psw_ff[10:8] |-> !IRQ_TAKE) else $error("masked level taken");
    a_irq_master: assert property (@(posedge CLK) disable iff (!RST_N)
        IRQ_ENTRY |=> !psw_ff[12] && psw_ff[13]) else $error("master bit not cleared");
    a_flush_empty: assert property (@(posedge CLK) disable iff (!RST_N)
        FLOW_VALID && FLOW_MISPRED |=> ib.empty && pfa_ff == $past(FLOW_TARGET)) else $error("flow not restarted");
endmodule : core_ctrl

// File: core_defs.svh
// constants for the core status and pipeline control block
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
`define RST_SP_ADDR      32'h0000_0000
`define RST_PC_ADDR      32'h0000_0004
`define TBL_ALIGN_BITS   20
`define TBL_KEEP_MASK    32'hfff0_0000
`define PSW_TRACE_BIT    15
`define PSW_SUPER_BIT    13
`define PSW_MASTER_BIT   12
`define PSW_MASK_LSB     8
`define PSW_WRITE_MASK   16'hb7ff
`define PSW_USER_MASK    16'h00ff
`define PSW_RESET        16'h2700
`define PREFETCH_STEP    32'h0000_0004
`define IBUF_DEPTH       3
`define CYC_REG_REG      3'h1
`define CYC_LOAD_LONG    3'h2
`define CYC_LOAD         3'h3
`define CYC_STORE        3'h1
`define CYC_RMW          3'h3
`define BASE_EN_BIT      0
`define BASE_WP_BIT      8
`define BASE_ADDR_MASK   32'hffff_0000
`endif

// File: core_pkg.sv
// types shared by the core status and pipeline control block
package core_pkg;
    typedef enum logic [2:0] {
        OP_REG_REG,
        OP_LOAD,
        OP_LOAD_LONG,
        OP_STORE,
        OP_RMW,
        OP_BRANCH
    } op_class_t;
    typedef enum logic [1:0] {
        CR_PSW,
        CR_TBL,
        CR_SRAM,
        CR_FLASH
    } ctl_reg_t;
endpackage : core_pkg

// File: core_status_and_pipeline_tb.sv
// testbench for the core status and pipeline control block
`timescale 1ns/1ps
module core_status_and_pipeline_tb
    import core_pkg::*;
;
    localparam logic [31:0] KEY = 32'h5a00_0000; // memory word = address xor key
    logic CLK, RST_N, BUS_REQ, BUS_WRITE, BUS_ACK, OPND_REQ, OPND_WRITE, OPND_DONE, INST_VALID, INST_TAKE;
    logic EXEC_BUSY, FLOW_VALID, FLOW_MISPRED, BR_COND, BR_BACKWARD, BR_PREDICT, CR_WE, INSN_DONE;
    logic TRACE_REQ, IRQ_EDGE7, IRQ_TAKE, IRQ_ENTRY, STK_SWAP_WE, SUPERVISOR, SRAM_HIT, FLASH_HIT;
    logic WRITE_BLOCK, slow;
    logic [31:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, OPND_ADDR, OPND_WDATA, OPND_RDATA, INST_WORD, a;
    logic [31:0] FLOW_TARGET, CR_WDATA, CR_RDATA, VEC_ADDR, STK_WDATA, ACTIVE_SP, ALT_SP;
    logic [9:0]  VEC_DISP;
    logic [2:0]  IRQ_LEVEL;
    op_class_t   INST_CLASS;
    ctl_reg_t    CR_SEL;
    int          miscompares, n_tests, n;
    op_class_t   cls[5] = '{OP_REG_REG, OP_LOAD, OP_LOAD_LONG, OP_STORE, OP_RMW};
    int          cyc[5] = '{1, 3, 2, 1, 3};
    core_ctrl i_core_ctrl (.CLK, .RST_N, .BUS_ADDR, .BUS_REQ, .BUS_WRITE, .BUS_WDATA, .BUS_RDATA, .BUS_ACK,
        .OPND_REQ, .OPND_WRITE, .OPND_ADDR, .OPND_WDATA, .OPND_DONE, .OPND_RDATA, .INST_WORD, .INST_VALID,
        .INST_TAKE, .INST_CLASS, .EXEC_BUSY, .FLOW_VALID, .FLOW_MISPRED, .FLOW_TARGET, .BR_COND, .BR_BACKWARD,
        .BR_PREDICT, .CR_WE, .CR_SEL, .CR_WDATA, .CR_RDATA, .INSN_DONE, .TRACE_REQ, .IRQ_LEVEL, .IRQ_EDGE7,
        .IRQ_TAKE, .IRQ_ENTRY, .VEC_DISP, .VEC_ADDR, .STK_SWAP_WE, .STK_WDATA, .ACTIVE_SP, .ALT_SP,
        .SUPERVISOR, .SRAM_HIT, .FLASH_HIT, .WRITE_BLOCK);
    mem_model i_mem_model (.CLK, .RST_N, .BUS_REQ, .BUS_ADDR, .SLOW(slow), .BUS_ACK, .BUS_RDATA);
    //==========================
    // helpers
    initial begin
        CLK = 0;
        forever #12.5 CLK = ~CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // inputs always move 1 ns after the edge
    task automatic tick(input int k = 1);
        repeat (k) @(posedge CLK);
        #1;
    endtask : tick
    task automatic next_cyc(output logic [31:0] adr);
        for (n = 0; n < 40 && !(BUS_REQ && BUS_ACK); n++) tick();
        adr = BUS_ADDR;
        tick();
    endtask : next_cyc
    task automatic cr_wr(input ctl_reg_t sel, input logic [31:0] d);
        CR_WE    = 1'b1;
        CR_SEL   = sel;
        CR_WDATA = d;
        tick();
        CR_WE = 0;
    endtask : cr_wr
    task automatic rd(input ctl_reg_t sel, input logic [31:0] exp);
        CR_SEL = sel;
        tick();
        chk(CR_RDATA, exp);
    endtask : rd
    // operand read or write, held until done; sram window at 0x2000_xxxx
    task automatic opnd(input logic w, input logic [31:0] adr);
        {OPND_REQ, OPND_WRITE, OPND_ADDR, OPND_WDATA} = {1'b1, w, adr, ~adr};
        for (n = 0; n < 20 && !OPND_DONE; n++) tick();
        chk(BUS_ADDR, adr);
        chk(w ? BUS_WDATA : OPND_RDATA, w ? ~adr : adr ^ KEY);
        chk(32'({BUS_WRITE, SRAM_HIT, FLASH_HIT, WRITE_BLOCK}), 32'({w, 2'b10, w}));
        tick();
        OPND_REQ = 0;
        tick(); // one idle edge before any next request
    endtask : opnd
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // watchdog, the sequence needs well under a thousand cycles
    initial begin
        #(4000 * 25);
        miscompares++;
        give_verdict();
    end
    //==========================
    // test sequence
    initial begin
        {RST_N, OPND_REQ, OPND_WRITE, INST_TAKE, FLOW_VALID, FLOW_MISPRED, BR_COND, BR_BACKWARD} = '0;
        {CR_WE, INSN_DONE, IRQ_EDGE7, IRQ_ENTRY, STK_SWAP_WE, slow, VEC_DISP, IRQ_LEVEL} = '0;
        {OPND_ADDR, OPND_WDATA, FLOW_TARGET, CR_WDATA, STK_WDATA, miscompares, n_tests} = '0;
        INST_CLASS = OP_REG_REG;
        CR_SEL = CR_PSW;
        tick(16);
        RST_N = 1;
        next_cyc(a); chk(a, 32'h0);
        next_cyc(a); chk(a, 32'h4);
        chk(ACTIVE_SP, KEY);
        slow = 1; // stretched answers, fetch must wait
        for (int i = 1; i < 4; i++) begin
            next_cyc(a); chk(a, KEY + 32'(4 * i));
        end
        chk(INST_WORD, 32'h4);
        tick(10); chk(32'(BUS_REQ), 32'h0);
        foreach (cls[i]) begin
            for (n = 0; n < 20 && !INST_VALID; n++) tick();
            INST_CLASS = cls[i];
            INST_TAKE  = 1'b1;
            tick();
            INST_TAKE = 0;
            for (n = 0; n < 9 && EXEC_BUSY; n++) tick();
            chk(32'(n), 32'(cyc[i] - 1));
        end
        cr_wr(CR_SRAM, 32'h2000_0101);
        opnd(1'b0, 32'h2000_0010);
        opnd(1'b1, 32'h2000_0020);
        BR_COND = 1;
        for (int b = 0; b < 2; b++) begin
            BR_BACKWARD = b[0]; tick(); chk(32'(BR_PREDICT), 32'(b));
        end
        {FLOW_VALID, FLOW_MISPRED, FLOW_TARGET} = {2'b11, 32'h0000_1000};
        tick();
        {FLOW_VALID, FLOW_MISPRED} = '0;
        chk(32'(INST_VALID), 32'h0);
        next_cyc(a); chk(a, 32'h0000_1000);
        rd(CR_PSW, 32'h0000_2700);
        cr_wr(CR_TBL, 32'hffff_ffff);
        rd(CR_TBL, 32'hfff0_0000);
        VEC_DISP = 10'h3fc; tick(); chk(VEC_ADDR, 32'hfff0_03fc);
        cr_wr(CR_PSW, 32'h0000_b7ff);
        rd(CR_PSW, 32'h0000_b7ff);
        INSN_DONE = 1; tick(); chk(32'(TRACE_REQ), 32'h1);
        INSN_DONE = 0; IRQ_ENTRY = 1; tick(); IRQ_ENTRY = 0;
        rd(CR_PSW, 32'h0000_27ff);
        cr_wr(CR_PSW, 32'h0000_2300);
        for (int l = 0; l < 8; l++) begin
            IRQ_LEVEL = l[2:0]; tick(); chk(32'(IRQ_TAKE), 32'(l > 3));
        end
        cr_wr(CR_PSW, 32'h0000_2700);
        chk(32'(IRQ_TAKE), 32'h0);
        IRQ_EDGE7 = 1; tick(); chk(32'(IRQ_TAKE), 32'h1);
        {STK_SWAP_WE, STK_WDATA} = {1'b1, 32'h0000_7700}; tick(); STK_SWAP_WE = 0;
        cr_wr(CR_PSW, 32'h0);
        chk(32'(SUPERVISOR), 32'h0);
        chk(ACTIVE_SP, 32'h0000_7700); chk(ALT_SP, KEY);
        rd(CR_TBL, 32'h0);
        cr_wr(CR_PSW, 32'h0000_b7ff);
        rd(CR_PSW, 32'h0000_00ff);
        chk(32'(SUPERVISOR), 32'h0);
        give_verdict();
    end
endmodule : core_status_and_pipeline_tb

// File: cycle_timer.sv
// per-instruction execute-stage cycle counter
`timescale 1ns/1ps
`include "core_defs.svh"
module cycle_timer
    import core_pkg::*;
(
    input  wire logic      clk,      // core clock
    input  wire logic      rst_n,    // synchronous reset, active low
    input  wire logic      start,    // issue of a new instruction
    input  wire op_class_t op,       // class of issued instruction
    output logic           busy,     // more cycles remain
    output logic           last      // final cycle of instruction
);
    logic [2:0] left_ff;

    function automatic logic [2:0] class_cycles(input op_class_t c);
        case (c)
            OP_REG_REG:   return `CYC_REG_REG;
            OP_LOAD:      return `CYC_LOAD;
            OP_LOAD_LONG: return `CYC_LOAD_LONG;
            OP_STORE:     return `CYC_STORE;
            OP_RMW:       return `CYC_RMW;
            default:      return 3'h1;
        endcase
    endfunction : class_cycles

    // loaded on issue, counts down to zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left_ff <= 3'h0;
        end else if (start) begin
            left_ff <= class_cycles(op) - 3'h1;
        end else if (left_ff != 3'h0) begin
            left_ff <= left_ff - 3'h1;
        end
    end

    assign busy = (left_ff != 3'h0);
    assign last = (left_ff == 3'h1) || (start && class_cycles(op) == 3'h1);

    a_load_three: assert property (@(posedge clk) disable iff (!rst_n)
        start && op == OP_LOAD |=> busy ##1 busy ##1 !busy) else $error("load not three cycles");
    a_long_two: assert property (@(posedge clk) disable iff (!rst_n)
        start && op == OP_LOAD_LONG |=> busy ##1 !busy) else $error("long load not two cycles");
    a_store_one: assert property (@(posedge clk) disable iff (!rst_n)
        start && op == OP_STORE |=> !busy) else $error("store not single cycle");
endmodule : cycle_timer

// File: ibuf_if.sv
// instruction buffer link between fetch and execute
`timescale 1ns/1ps
interface ibuf_if;
    logic        push;
    logic [31:0] push_data;
    logic        pop;
    logic [31:0] pop_data;
    logic        empty;
    logic        full;
    logic        flush;
    modport fill  (output push, output push_data, output flush, input full);
    modport drain (output pop, input pop_data, input empty);
    modport buf_side (input push, input push_data, input pop, input flush,
                      output pop_data, output empty, output full);
endinterface : ibuf_if

// File: inst_buffer.sv
// three-entry instruction buffer between fetch and execute
`timescale 1ns/1ps
`include "core_defs.svh"
module inst_buffer
    import core_pkg::*;
(
    input  wire logic clk,      // core clock
    input  wire logic rst_n,    // synchronous reset, active low
    ibuf_if.buf_side  ib        // fill and drain sides
);
    logic [31:0] mem_ff [`IBUF_DEPTH];
    logic [1:0]  wp_ff;
    logic [1:0]  rp_ff;
    logic [1:0]  cnt_ff;

    function automatic logic [1:0] wrap_inc(input logic [1:0] p);
        return (p == 2'h2) ? 2'h0 : p + 2'h1;
    endfunction : wrap_inc

    assign ib.empty    = (cnt_ff == 2'h0);
    assign ib.full     = (cnt_ff == 2'h3);
    assign ib.pop_data = mem_ff[rp_ff];

    // storage; a push while full is dropped, the filler must watch full
    always_ff @(posedge clk) begin
        if (ib.push && !ib.full && !ib.flush) begin
            mem_ff[wp_ff] <= ib.push_data;
        end
    end

    // pointers and count; flush throws away stale sequential words
    always_ff @(posedge clk) begin
        if (!rst_n || ib.flush) begin
            wp_ff  <= 2'h0;
            rp_ff  <= 2'h0;
            cnt_ff <= 2'h0;
        end else begin
            if (ib.push && !ib.full) wp_ff <= wrap_inc(wp_ff);
            if (ib.pop && !ib.empty) rp_ff <= wrap_inc(rp_ff);
            cnt_ff <= cnt_ff + {1'b0, ib.push && !ib.full} - {1'b0, ib.pop && !ib.empty};
        end
    end

    a_buf_count: assert property (@(posedge clk) disable iff (!rst_n)
        ib.push && !ib.full && !ib.flush && !(ib.pop && !ib.empty)
        |=> cnt_ff == $past(cnt_ff) + 2'h1) else $error("buffer push lost");
endmodule : inst_buffer

// File: mem_model.sv
// local memory model for the core bus
`timescale 1ns/1ps
module mem_model (
    input  wire logic        CLK,      // core clock
    input  wire logic        RST_N,    // reset, active low
    input  wire logic        BUS_REQ,  // cycle request
    input  wire logic [31:0] BUS_ADDR, // address
    input  wire logic        SLOW,     // add wait states
    output logic             BUS_ACK,  // cycle done
    output logic [31:0]      BUS_RDATA // read data
);
    logic [2:0]  wait_ff;
    logic [31:0] last_ff;
    //==========================
    // memory behaviour
    // wait states; slow mode exercises fetch stalls
    always_ff @(posedge CLK) begin
        // an abandoned request must not leave a head start for the next one
        if (!RST_N || BUS_ACK || !BUS_REQ) wait_ff <= 3'h0;
        else if (BUS_REQ) wait_ff <= wait_ff + 3'h1;
    end
    // keep last word so an idle read bus never repeats it
    always_ff @(posedge CLK) begin
        if (!RST_N) last_ff <= 32'h0;
        else if (BUS_ACK) last_ff <= BUS_RDATA;
    end
    assign BUS_ACK = BUS_REQ && (wait_ff >= (SLOW ? 3'h4 : 3'h1));
    // separate read path, word is address xor key
    assign BUS_RDATA = BUS_ACK ? BUS_ADDR ^ 32'h5a00_0000 : ~last_ff;
endmodule : mem_model
